//--- core/bcrm_pkg.sv
// Shared constants for the bus info and ROM map register bank
package bcrm_pkg;
  // Register offsets on the local register port
  localparam logic [7:0] OFF_BUS_ID = 8'h1c;
  localparam logic [7:0] OFF_BUS_OPT = 8'h20;
  localparam logic [7:0] OFF_UID_HI = 8'h24;
  localparam logic [7:0] OFF_UID_LO = 8'h28;
  localparam logic [7:0] OFF_ROM_MAP = 8'h34;
  // Constant bus identification quadlet
  localparam logic [31:0] BUS_ID_VAL = 32'h31333934;
  // Bus options field positions
  localparam int MAX_REC_LSB = 12;
  localparam int GEN_LSB = 6;
  localparam int SPD_LSB = 0;
  // Max receive code 9 means 2^(9+1) = 1024 bytes
  localparam logic [3:0] MAX_REC_RST = 4'h9;
  // Link speed codes
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h1;
  localparam logic [2:0] SPD_S400 = 3'h2;
  localparam logic [2:0] SPD_RST = SPD_S400;
  // Map base field position and reset
  localparam int ROM_BASE_LSB = 10;
  localparam logic [21:0] ROM_BASE_RST = 22'h0;
  localparam logic [31:0] UID_RST = 32'h0;
  // Mapped ROM window, 1 KB starting here
  localparam logic [47:0] ROM_WIN_BASE = 48'hffff_f000_0400;
  localparam logic [7:0] ROM_LOCAL_QUADS = 8'h05;
  // Transaction codes seen by the block
  localparam logic [3:0] TC_WR_QUAD = 4'h0;
  localparam logic [3:0] TC_WR_BLK = 4'h1;
  localparam logic [3:0] TC_RD_QUAD = 4'h4;

  // Largest block payload in bytes for a max receive code
  function automatic logic [16:0] bcrm_max_bytes(input logic [3:0] code);
    bcrm_max_bytes = 17'h1 << (code + 4'h1);
  endfunction
endpackage

//--- core/bcrm_uid_word.sv
// Write-once unique ID word
`timescale 1ns/1ps
module bcrm_uid_word (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_wr,
  input wire logic [31:0] host_data,
  input wire logic auto_ld,
  input wire logic [31:0] auto_data,
  output logic [31:0] value,
  output logic loaded
);
  import bcrm_pkg::*;

  typedef struct packed {
    logic [31:0] value;
    logic loaded;
  } bcrm_uid_s;

  bcrm_uid_s cur_ff;
  bcrm_uid_s nxt_cur;

  // Only the first load sticks; soft reset never reaches this word
  always_comb begin
    nxt_cur = cur_ff;
    if (!cur_ff.loaded) begin
      if (auto_ld) begin
        nxt_cur.value = auto_data;
        nxt_cur.loaded = 1'b1;
      end else if (host_wr) begin
        nxt_cur.value = host_data;
        nxt_cur.loaded = 1'b1;
      end
    end
  end

  // Power-on reset leaves the illegal all-zero ID
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{value: UID_RST, loaded: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign value = cur_ff.value;
  assign loaded = cur_ff.loaded;

  AST_UID_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    loaded |=> $stable(value) && loaded)
    else $error("unique ID changed after load");
  AST_UID_TAKE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !loaded && host_wr && !auto_ld |=> loaded && value == $past(host_data))
    else $error("first unique ID write not taken");
endmodule

//--- core/bcrm_req_class.sv
// Classifies a remote request against the ROM window and max receive size
`timescale 1ns/1ps
module bcrm_req_class (
  input wire logic [3:0] tcode,
  input wire logic [47:0] offset,
  input wire logic [15:0] blk_len,
  input wire logic [3:0] max_rec,
  input wire logic phys_handled,
  output logic in_rom,
  output logic rom_quad_rd,
  output logic rom_local,
  output logic blk_too_long
);
  import bcrm_pkg::*;

  // Window is exactly 1 KB, so the top 38 bits decide membership
  always_comb begin
    in_rom = offset[47:10] == ROM_WIN_BASE[47:10];
    rom_quad_rd = in_rom && (tcode == TC_RD_QUAD);
    rom_local = offset[9:2] < ROM_LOCAL_QUADS;
    // Physical unit may still take long writes; we then let it answer
    blk_too_long = (tcode == TC_WR_BLK) && !phys_handled
      && ({1'b0, blk_len} > bcrm_max_bytes(max_rec));
  end
endmodule

//--- core/bcrm_top.sv
// Bus info block, unique ID and configuration ROM mapping registers
//
// Contract
// - Hard reset max_rec 1024 or EEPROM; soft keeps
// - Overlong block write gets ack_type_error unless phys_handled
// - Generation increments when ROM changed since reset
// - Speed codes 100, 200, 400 Mbit/s
// - Hard reset speed 400 or EEPROM value
// - Unprotected speed may be lowered; faster packets rejected
// - Only ROM quadlet reads mapped; others error
// - Host address is base plus low offset
// - Base low ten bits read zero, aligned
// - First five ROM quadlets served locally
// - Hard reset clears unique ID; soft keeps
// - Unique ID accepts one load only
// - Load from local source or firmware write
`timescale 1ns/1ps
module bcrm_top #(
  parameter logic [31:0] ROM_HDR_VAL = 32'h0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic ee_load,
  input wire logic [3:0] ee_max_rec,
  input wire logic [2:0] ee_link_spd,
  input wire logic [31:0] ee_uid_high,
  input wire logic [31:0] ee_uid_low,
  input wire logic spd_write_protect,
  input wire logic bus_reset,
  input wire logic rom_changed,
  input wire logic req_valid,
  input wire logic [3:0] req_tcode,
  input wire logic [47:0] req_offset,
  input wire logic [15:0] req_len,
  input wire logic [2:0] req_speed,
  input wire logic phys_handled,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic ack_type_err,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic speed_reject
);
  import bcrm_pkg::*;

  typedef struct packed {
    logic [3:0] max_rec;
    logic [1:0] gen;
    logic [2:0] spd;
    logic [21:0] rom_base;
    logic rom_dirty;
    logic [31:0] rdata;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic ack_err;
    logic fetch_valid;
    logic [31:0] fetch_addr;
    logic reject;
  } bcrm_top_s;

  bcrm_top_s cur_ff;
  bcrm_top_s nxt_cur;

  logic [31:0] uid_high;
  logic [31:0] uid_low;
  logic uid_high_loaded;
  logic uid_low_loaded;
  logic in_rom;
  logic rom_quad_rd;
  logic rom_local;
  logic blk_too_long;
  logic wr_busopt;
  logic wr_map;
  logic uid_high_wr;
  logic uid_low_wr;
  logic [31:0] busopt_word;
  logic [2:0] wr_spd;

  // Register write decode
  assign wr_busopt = reg_wr && (reg_addr == OFF_BUS_OPT);
  assign wr_map = reg_wr && (reg_addr == OFF_ROM_MAP);
  assign uid_high_wr = reg_wr && (reg_addr == OFF_UID_HI);
  assign uid_low_wr = reg_wr && (reg_addr == OFF_UID_LO);
  assign wr_spd = reg_wdata[SPD_LSB +: 3];

  // Upper bus option fields live elsewhere and read as zero here
  always_comb begin
    busopt_word = 32'h0;
    busopt_word[MAX_REC_LSB +: 4] = cur_ff.max_rec;
    busopt_word[GEN_LSB +: 2] = cur_ff.gen;
    busopt_word[SPD_LSB +: 3] = cur_ff.spd;
  end

  // Each ID word not yet loaded takes the local source on ee_load, or one host write each
  bcrm_uid_word u_uid_high (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_wr(uid_high_wr),
    .host_data(reg_wdata),
    .auto_ld(ee_load),
    .auto_data(ee_uid_high),
    .value(uid_high),
    .loaded(uid_high_loaded)
  );

  bcrm_uid_word u_uid_low (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_wr(uid_low_wr),
    .host_data(reg_wdata),
    .auto_ld(ee_load),
    .auto_data(ee_uid_low),
    .value(uid_low),
    .loaded(uid_low_loaded)
  );

  bcrm_req_class u_class (
    .tcode(req_tcode),
    .offset(req_offset),
    .blk_len(req_len),
    .max_rec(cur_ff.max_rec),
    .phys_handled(phys_handled),
    .in_rom(in_rom),
    .rom_quad_rd(rom_quad_rd),
    .rom_local(rom_local),
    .blk_too_long(blk_too_long)
  );

  // All state moves here; pulses drop after one cycle
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp_valid = 1'b0;
    nxt_cur.ack_err = 1'b0;
    nxt_cur.fetch_valid = 1'b0;
    nxt_cur.reject = 1'b0;

    // Host register writes
    if (wr_busopt) begin
      nxt_cur.max_rec = reg_wdata[MAX_REC_LSB +: 4];
      nxt_cur.gen = reg_wdata[GEN_LSB +: 2];
      // Only downward moves to a defined code; protect bit freezes it
      if (!spd_write_protect && wr_spd <= cur_ff.spd && wr_spd <= SPD_S400) begin
        nxt_cur.spd = wr_spd;
      end
    end
    if (wr_map) begin
      nxt_cur.rom_base = reg_wdata[31:ROM_BASE_LSB];
    end
    // Local source values override max_rec and link speed on every ee_load pulse, even over a host write
    if (ee_load) begin
      nxt_cur.max_rec = ee_max_rec;
      nxt_cur.spd = ee_link_spd;
    end

    // A change in the same cycle as a bus reset stays pending for the next
    if (bus_reset) begin
      if (cur_ff.rom_dirty) begin
        nxt_cur.gen = cur_ff.gen + 2'h1;
      end
      nxt_cur.rom_dirty = 1'b0;
    end
    if (rom_changed || wr_map || wr_busopt || uid_high_wr || uid_low_wr || ee_load) begin
      nxt_cur.rom_dirty = 1'b1;
    end

    // Registered read data, unmapped reads give zero
    nxt_cur.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_BUS_ID: nxt_cur.rdata = BUS_ID_VAL;
        OFF_BUS_OPT: nxt_cur.rdata = busopt_word;
        OFF_UID_HI: nxt_cur.rdata = uid_high;
        OFF_UID_LO: nxt_cur.rdata = uid_low;
        OFF_ROM_MAP: nxt_cur.rdata = {cur_ff.rom_base, 10'h0};
        default: nxt_cur.rdata = 32'h0;
      endcase
    end

    // Remote request handling, speed check first
    if (req_valid) begin
      if (req_speed > cur_ff.spd) begin
        nxt_cur.reject = 1'b1;
      end else if (in_rom && !rom_quad_rd) begin
        nxt_cur.ack_err = 1'b1;
      end else if (rom_quad_rd && rom_local) begin
        // Header and bus info block never touch host memory
        nxt_cur.rsp_valid = 1'b1;
        unique case (req_offset[4:2])
          3'h0: nxt_cur.rsp_data = ROM_HDR_VAL;
          3'h1: nxt_cur.rsp_data = BUS_ID_VAL;
          3'h2: nxt_cur.rsp_data = busopt_word;
          3'h3: nxt_cur.rsp_data = uid_high;
          3'h4: nxt_cur.rsp_data = uid_low;
          default: nxt_cur.rsp_data = 32'h0;
        endcase
      end else if (rom_quad_rd) begin
        // Aligned base means the sum is a plain concatenation
        nxt_cur.fetch_valid = 1'b1;
        nxt_cur.fetch_addr = {cur_ff.rom_base, req_offset[9:0]};
      end else if (blk_too_long) begin
        nxt_cur.ack_err = 1'b1;
      end
    end

    // Soft reset only drops in-flight pulses; max_rec and link speed kept
    if (soft_rst) begin
      nxt_cur.rsp_valid = 1'b0;
      nxt_cur.ack_err = 1'b0;
      nxt_cur.fetch_valid = 1'b0;
      nxt_cur.reject = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{max_rec: MAX_REC_RST, gen: 2'h0, spd: SPD_RST, rom_base: ROM_BASE_RST,
        rom_dirty: 1'b0, rdata: 32'h0, rsp_valid: 1'b0, rsp_data: 32'h0, ack_err: 1'b0,
        fetch_valid: 1'b0, fetch_addr: 32'h0, reject: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign rsp_valid = cur_ff.rsp_valid;
  assign rsp_data = cur_ff.rsp_data;
  assign ack_type_err = cur_ff.ack_err;
  assign fetch_valid = cur_ff.fetch_valid;
  assign fetch_addr = cur_ff.fetch_addr;
  assign speed_reject = cur_ff.reject;

  AST_GEN_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_reset && cur_ff.rom_dirty && !wr_busopt |=> cur_ff.gen == $past(cur_ff.gen) + 2'h1)
    else $error("generation did not advance");
  AST_GEN_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_reset && !cur_ff.rom_dirty && !wr_busopt |=> $stable(cur_ff.gen))
    else $error("generation moved without ROM change");
  AST_SPD_REJECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed > cur_ff.spd |=> speed_reject && !fetch_valid
      && !rsp_valid && !ack_type_err)
    else $error("fast packet not rejected");
  AST_SPD_WP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_busopt && spd_write_protect && !ee_load |=> $stable(cur_ff.spd))
    else $error("protected link speed changed");
  AST_ROM_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed <= cur_ff.spd && rom_quad_rd && !rom_local
      |=> fetch_valid && fetch_addr == {$past(cur_ff.rom_base), $past(req_offset[9:0])}
      && fetch_addr[9:0] >= 10'h014)
    else $error("ROM fetch address wrong");
  AST_ROM_LOCAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed <= cur_ff.spd && rom_quad_rd && rom_local
      |=> rsp_valid && !fetch_valid)
    else $error("local ROM quadlet fetched from host");
  AST_ROM_NONQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed <= cur_ff.spd && in_rom && req_tcode != TC_RD_QUAD
      |=> ack_type_err && !fetch_valid)
    else $error("non-quadlet ROM access not errored");
  AST_BLK_LONG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed <= cur_ff.spd && !in_rom && req_tcode == TC_WR_BLK
      && !phys_handled && {1'b0, req_len} > bcrm_max_bytes(cur_ff.max_rec) |=> ack_type_err)
    else $error("overlong block write accepted");
  AST_MAXREC_SOFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst && !wr_busopt && !ee_load |=> $stable(cur_ff.max_rec) && $stable(cur_ff.spd))
    else $error("soft reset disturbed max_rec");
  AST_MAP_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_ROM_MAP |=> reg_rdata[9:0] == 10'h0)
    else $error("map base low bits not zero");

  // Remote answers are single pulses and never overlap, so the far side
  // can treat any one of them as the complete reply to its request
  AST_ONE_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0({rsp_valid, ack_type_err, fetch_valid, speed_reject}))
    else $error("more than one remote answer at once");
  AST_REQ_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !req_valid |=> !rsp_valid && !ack_type_err && !fetch_valid && !speed_reject)
    else $error("remote answer without a request");
  AST_OUT_WIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_valid && !soft_rst && req_speed <= cur_ff.spd && !in_rom |=> !fetch_valid && !rsp_valid)
    else $error("request outside ROM window mapped");
  AST_SOFT_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst |=> !rsp_valid && !ack_type_err && !fetch_valid && !speed_reject)
    else $error("answer pulse survived soft reset");
  AST_UID_SOFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst && uid_high_loaded && uid_low_loaded |=> $stable(uid_high) && $stable(uid_low))
    else $error("soft reset disturbed unique ID");
  AST_SPD_UP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_busopt && !ee_load && wr_spd > cur_ff.spd |=> $stable(cur_ff.spd))
    else $error("link speed raised by software");
  AST_SPD_LOWER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_busopt && !ee_load && !spd_write_protect && wr_spd <= cur_ff.spd && wr_spd <= SPD_S400
      |=> cur_ff.spd == $past(wr_spd))
    else $error("permitted link speed write lost");
  AST_EE_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ee_load |=> cur_ff.max_rec == $past(ee_max_rec) && cur_ff.spd == $past(ee_link_spd))
    else $error("local source values not loaded");
  AST_UID_EE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ee_load && !uid_low_loaded |=> uid_low == $past(ee_uid_low) && uid_low_loaded)
    else $error("local unique ID load not taken");
endmodule

//--- tb/bcrm_remote_node.sv
// Remote node model that issues requests toward the register bank
`timescale 1ns/1ps
module bcrm_remote_node (
  input wire logic ref_clk,
  output logic req_valid,
  output logic [3:0] req_tcode,
  output logic [47:0] req_offset,
  output logic [15:0] req_len,
  output logic [2:0] req_speed,
  output logic phys_handled
);
  // Idle state at time zero
  initial begin
    req_valid = 1'b0;
    {req_tcode, req_offset, req_len, req_speed, phys_handled} = '0;
  end

  // One request for one cycle; released lines flip so stale values never look valid
  task automatic send(input logic [3:0] tc, input logic [47:0] off, input logic [15:0] len,
                      input logic [2:0] spd, input logic ph);
    @(negedge ref_clk);
    req_valid = 1'b1;
    {req_tcode, req_offset, req_len, req_speed, phys_handled} = {tc, off, len, spd, ph};
    @(negedge ref_clk);
    req_valid = 1'b0;
    {req_tcode, req_offset, req_len, req_speed, phys_handled} = ~{tc, off, len, spd, ph};
  endtask
endmodule

//--- tb/bcrm_top_bench.sv
// Self-checking bench for the bus info and ROM map register bank
`timescale 1ns/1ps
module bcrm_top_bench;
  import bcrm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_rst = 1'b0, bus_reset = 1'b0, rom_changed = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ee_load = 1'b0, spd_write_protect = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, ee_uid_high = 32'h0, ee_uid_low = 32'h0;
  logic [3:0] ee_max_rec = 4'h0;
  logic [2:0] ee_link_spd = 3'h0;
  logic [31:0] reg_rdata, rsp_data, fetch_addr, d, r, uh, ul;
  logic rsp_valid, ack_type_err, fetch_valid, speed_reject, req_valid, phys_handled;
  logic [3:0] req_tcode;
  logic [47:0] req_offset;
  logic [15:0] req_len;
  logic [2:0] req_speed;
  logic [9:0] o;
  int error_cnt = 0;
  int checked = 0;

  bcrm_top u_bcrm_top (.ref_clk(ref_clk), .rst_n(rst_n), .soft_rst(soft_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ee_load(ee_load), .ee_max_rec(ee_max_rec),
    .ee_link_spd(ee_link_spd), .ee_uid_high(ee_uid_high), .ee_uid_low(ee_uid_low),
    .spd_write_protect(spd_write_protect), .bus_reset(bus_reset),
    .rom_changed(rom_changed), .req_valid(req_valid), .req_tcode(req_tcode),
    .req_offset(req_offset), .req_len(req_len), .req_speed(req_speed),
    .phys_handled(phys_handled), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .ack_type_err(ack_type_err), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .speed_reject(speed_reject));
  bcrm_remote_node u_bcrm_remote_node (.ref_clk(ref_clk), .req_valid(req_valid),
    .req_tcode(req_tcode), .req_offset(req_offset), .req_len(req_len),
    .req_speed(req_speed), .phys_handled(phys_handled));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Register strobes last one cycle; data lines flip once released
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge ref_clk);
    {reg_wr, reg_wdata} = {1'b0, ~v};
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Pulse of {soft_rst, bus_reset, rom_changed}
  task automatic pulse(input logic [2:0] m);
    @(negedge ref_clk);
    {soft_rst, bus_reset, rom_changed} = m;
    @(negedge ref_clk);
    {soft_rst, bus_reset, rom_changed} = 3'h0;
  endtask

  task automatic hard_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
  endtask

  // Request, then flags {rsp, ack, fetch, reject} one cycle later
  task automatic req(input logic [3:0] tc, input logic [47:0] off, input logic [15:0] len,
                     input logic [2:0] spd, input logic ph, input logic [3:0] exp);
    u_bcrm_remote_node.send(tc, off, len, spd, ph);
    chk({28'h0, rsp_valid, ack_type_err, fetch_valid, speed_reject}, {28'h0, exp});
  endtask

  function automatic logic [31:0] bo(input logic [3:0] mr, input logic [1:0] g,
                                     input logic [2:0] s);
    bo = {16'h0, mr, 4'h0, g, 3'h0, s};
  endfunction

  // Watchdog sized well beyond the hundred or so cycles the tests take
  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(11));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(OFF_BUS_OPT);
    chk(d, bo(MAX_REC_RST, 2'h0, SPD_S400));
    rd(OFF_UID_HI);
    chk(d, 32'h0);
    rd(8'h40);
    chk(d, 32'h0);
    $display("test reset values done");
    uh = $urandom | 32'h1;
    ul = $urandom | 32'h1;
    wr(OFF_UID_HI, uh);
    wr(OFF_UID_HI, ~uh);
    wr(OFF_UID_LO, ul);
    wr(OFF_UID_LO, ~ul);
    rd(OFF_UID_HI);
    chk(d, uh);
    rd(OFF_UID_LO);
    chk(d, ul);
    $display("test unique id done");
    pulse(3'b010);
    pulse(3'b010);
    rd(OFF_BUS_OPT);
    chk({30'h0, d[7:6]}, 32'h1);
    pulse(3'b001);
    pulse(3'b010);
    rd(OFF_BUS_OPT);
    chk({30'h0, d[7:6]}, 32'h2);
    $display("test generation done");
    pulse(3'b100);
    rd(OFF_UID_LO);
    chk(d, ul);
    rd(OFF_BUS_OPT);
    chk({28'h0, d[15:12]}, {28'h0, MAX_REC_RST});
    $display("test soft reset done");
    r = $urandom;
    wr(OFF_ROM_MAP, r);
    rd(OFF_ROM_MAP);
    chk(d, r & 32'hffff_fc00);
    for (int i = 0; i < 5; i++) begin
      req(TC_RD_QUAD, ROM_WIN_BASE + 48'(4 * i), 16'h0, SPD_S400, 1'b0, 4'b1000);
      if (i == 1) chk(rsp_data, BUS_ID_VAL);
      if (i == 2) chk(rsp_data, bo(MAX_REC_RST, 2'h2, SPD_S400));
      if (i == 3) chk(rsp_data, uh);
      if (i == 4) chk(rsp_data, ul);
    end
    o = 10'h014 + 10'(4 * ($urandom % 251));
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'(o), 16'h0, SPD_S400, 1'b0, 4'b0010);
    chk(fetch_addr, {r[31:10], o});
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'h3fc, 16'h0, SPD_S400, 1'b0, 4'b0010);
    chk(fetch_addr, {r[31:10], 10'h3fc});
    req(TC_WR_QUAD, ROM_WIN_BASE + 48'h20, 16'h4, SPD_S400, 1'b0, 4'b0100);
    req(TC_WR_BLK, ROM_WIN_BASE + 48'h40, 16'h8, SPD_S400, 1'b1, 4'b0100);
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'h400, 16'h0, SPD_S400, 1'b0, 4'b0000);
    $display("test rom map done");
    req(TC_WR_BLK, 48'h1000, 16'd1025, SPD_S100, 1'b0, 4'b0100);
    req(TC_WR_BLK, 48'h1000, 16'd1024, SPD_S100, 1'b0, 4'b0000);
    req(TC_WR_BLK, 48'h1000, 16'd2000, SPD_S100, 1'b1, 4'b0000);
    $display("test block length done");
    rd(OFF_BUS_OPT);
    spd_write_protect = 1'b1;
    wr(OFF_BUS_OPT, bo(MAX_REC_RST, d[7:6], SPD_S200));
    rd(OFF_BUS_OPT);
    chk({29'h0, d[2:0]}, {29'h0, SPD_S400});
    spd_write_protect = 1'b0;
    wr(OFF_BUS_OPT, bo(MAX_REC_RST, d[7:6], SPD_S200));
    rd(OFF_BUS_OPT);
    chk({29'h0, d[2:0]}, {29'h0, SPD_S200});
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'h100, 16'h0, SPD_S400, 1'b0, 4'b0001);
    wr(OFF_BUS_OPT, bo(MAX_REC_RST, d[7:6], SPD_S100));
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'h100, 16'h0, SPD_S200, 1'b0, 4'b0001);
    req(TC_RD_QUAD, ROM_WIN_BASE + 48'h100, 16'h0, SPD_S100, 1'b0, 4'b0010);
    $display("test link speed done");
    hard_reset();
    rd(OFF_UID_LO);
    chk(d, 32'h0);
    uh = $urandom | 32'h1;
    ul = $urandom | 32'h1;
    @(negedge ref_clk);
    {ee_load, ee_max_rec, ee_link_spd, ee_uid_high, ee_uid_low} = {1'b1, 4'h8, SPD_S200, uh, ul};
    @(negedge ref_clk);
    ee_load = 1'b0;
    wr(OFF_UID_HI, ~uh);
    rd(OFF_BUS_OPT);
    chk(d, bo(4'h8, 2'h0, SPD_S200));
    rd(OFF_UID_HI);
    chk(d, uh);
    rd(OFF_UID_LO);
    chk(d, ul);
    $display("test local load done");
    tally_and_finish();
  end
endmodule
